// ===== design/msd_pkg.sv
// shared constants and carriers of the memory space decoder
package msd_pkg;
	// register indexes on the plain register port
	localparam logic [7:0] REG_SLOT_PTR = 8'h02;
	localparam logic [7:0] REG_STRAP_STAT = 8'h0B;
	localparam logic [7:0] REG_MAP_CTRL = 8'h0C;
	localparam logic [7:0] REG_DRAM_SIZE = 8'h0D;
	localparam logic [7:0] REG_SEG_AB = 8'h0E;
	localparam logic [7:0] REG_SEG_C = 8'h0F;
	localparam logic [7:0] REG_SEG_D = 8'h10;
	localparam logic [7:0] REG_SEG_EF = 8'h11;
	// memory_map_control field positions
	localparam int MAP_REMAP_BIT = 4;
	localparam int MAP_REL_LO_BIT = 5;
	localparam int MAP_REL_HI_BIT = 6;
	// reset values
	localparam logic [7:0] PTR_RST = 8'hFF;
	localparam logic [7:0] SEG_RST = 8'h00;
	localparam logic [7:0] MAP_RST = 8'h00;
	localparam logic [7:0] SIZE_RST = 8'h01;
	// pointer classes
	localparam logic [7:0] PTR_SRAM = 8'h00;
	localparam logic [7:0] PTR_LOW_MIN = 8'h04;
	localparam logic [7:0] PTR_LOW_MAX = 8'h09;
	localparam logic [7:0] PTR_MID_MIN = 8'h0A;
	localparam logic [7:0] PTR_MID_MAX = 8'h0F;
	localparam logic [7:0] PTR_MID_AS = 8'h10;
	localparam logic [7:0] PTR_SLOT_MAX = 8'hFD;
	// 64K segment bounds on address bits 23..16
	localparam logic [7:0] SEG_640K = 8'h0A;
	localparam logic [7:0] SEG_1M = 8'h10;
	localparam logic [7:0] REMAP_LEN = 8'h06;
	localparam logic [6:0] ROM_TOP_128K = 7'h7F;
	// strap capture delay after reset release
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// processor memory request, A24 flags beyond 16M
	typedef struct packed {
		logic valid;
		logic write;
		logic wide;
		logic [24:0] addr;
	} msd_req_t;
	// cycle start to the generators
	typedef struct packed {
		logic dram_start;
		logic sram_start;
		logic rom_start;
		logic slot_start;
		logic no_cycle;
		logic split;
		logic [23:0] dram_addr;
	} msd_cyc_t;
endpackage

// ===== design/msd_decoder.sv
// Notes on behaviour
// RL1: pointer zero never starts a DRAM cycle
// RL2: pointer 04h-09h splits base memory with slots
// RL3: window by access codes, beyond 16M nothing
// RL4: pointer 0Ah-0Fh behaves as 10h
// RL5: pointer 10h-FFh keeps base and extended onboard
// RL6: above pointer: slots to FDh, else ROM
// RL7: remap bit moves 384K DRAM to top
// RL8: remap only with 1M to 4M DRAM
// RL9: remap turns all shadowing off
// RL10: relocation bits steer C and E ROM ranges
// RL11: relocation bits loaded from straps at reset
// RL12: relocation bits never touch DRAM addresses
// RL13: straps pick ROM bus and ROM width
// RL14: 8-bit ROM lane fixed, chip select asserted
// RL15: software duplicates bytes for local 8-bit flash
// RL16: ROM writes are never split
// RL17: two-bit codes per 16K or 32K segment
// RL18: every segment code acts on its own
// RL19: code 10 reads DRAM, writes slots
// RL20: software copies ROM using code 01 first
// RL21: code 11 full DRAM, code 00 slots or ROM
// RL22: eight-bit pointer against A23-A16
// RL23: software never writes pointer 01h-03h
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module msd_decoder
	import msd_pkg::*;
#(
	parameter int REMAP_MB_MAX = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire msd_req_t req,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] strap_reloc,
	input wire logic strap_rom_slot,
	input wire logic rom_width_strap,
	output msd_cyc_t cyc,
	output logic rom_chip_select_n,
	output logic rom_on_slot_bus,
	output logic rom_8bit,
	output logic rom_lane_hi,
	output logic [7:0] reg_rdata
);
	// remap limit must fit the 4-bit size field
	generate
		if (REMAP_MB_MAX < 1 || REMAP_MB_MAX > 15) begin : g_bad
			$error("REMAP_MB_MAX out of range");
		end
	endgenerate

	localparam logic [7:0] REMAP_MAX = 8'(REMAP_MB_MAX);

	// reset release synchroniser
	logic rst_meta_n_reg;
	logic rst_n_reg;
	// strap synchronisers
	logic [3:0] strap_meta_reg;
	logic [3:0] strap_sync_reg;
	// strap capture sequencing
	logic [1:0] strap_cnt_reg;
	logic strap_done_reg;
	// software registers
	logic [7:0] ptr_reg;
	logic [7:0] seg_ab_reg;
	logic [7:0] seg_c_reg;
	logic [7:0] seg_d_reg;
	logic [7:0] seg_ef_reg;
	logic [7:0] map_reg;
	logic [7:0] size_reg;
	// outputs
	msd_cyc_t cyc_reg;
	logic rom_cs_n_reg;
	logic rom_slot_reg;
	logic rom_8bit_reg;
	logic [7:0] rdata_reg;

	// two-bit access code of the segment holding addr
	function automatic logic [1:0] seg_code(
		input logic [19:14] a,
		input logic [7:0] ab,
		input logic [7:0] c,
		input logic [7:0] d,
		input logic [7:0] ef
	);
		logic [7:0] r;
		logic [1:0] i;
		r = ab;
		i = a[16:15];
		// 16K granules in C and D, 32K elsewhere
		case (a[19:17])
			// A and B share one register
			3'h5: begin
				r = ab;
				i = a[16:15];
			end
			// C and D pick their register by bit 16
			3'h6: begin
				r = a[16] ? d : c;
				i = a[15:14];
			end
			// E and F share one register
			3'h7: begin
				r = ef;
				i = a[16:15];
			end
			// outside the window the code goes unused
			default: begin
				r = ab;
				i = a[16:15];
			end
		endcase
		seg_code = r[2*i +: 2]; // RL17 RL18
	endfunction

	// does the default map place addr in ROM
	function automatic logic rom_space(
		input logic [19:15] a,
		input logic [1:0] rel
	);
		logic hit;
		hit = 1'b0;
		case (a[19:15])
			// system BIOS range answers as ROM whatever the bits
			5'h1E: hit = 1'b1; // RL10
			5'h1F: hit = 1'b1;
			5'h1C: hit = (rel == 2'b00); // RL10
			5'h1D: hit = (rel == 2'b00) || (rel == 2'b10);
			5'h18: hit = rel[1]; // RL10
			5'h19: hit = (rel == 2'b11);
			default: hit = 1'b0;
		endcase
		rom_space = hit;
	endfunction

	// reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		// pin low clears both stages at once
		if (!nrst) begin
			rst_meta_n_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			// ones ripple through, release two edges later
			rst_meta_n_reg <= 1'b1;
			rst_n_reg <= rst_meta_n_reg;
		end
	end

	// strap pins pass two flops
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			strap_meta_reg <= 4'h0;
			strap_sync_reg <= 4'h0;
		end else begin
			// first stage only feeds the second
			strap_meta_reg <= {rom_width_strap, strap_rom_slot, strap_reloc};
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// strap fields after synchronising
	wire [1:0] strap_rel = strap_sync_reg[1:0];
	wire strap_slot = strap_sync_reg[2];
	wire strap_wide = strap_sync_reg[3];

	// capture fires once, after the sync pipe settles
	wire strap_take = !strap_done_reg && (strap_cnt_reg == STRAP_WAIT);
	wire [1:0] strap_cnt_next = strap_done_reg ? strap_cnt_reg
		: 2'(strap_cnt_reg + 2'h1);

	// register write decode
	wire wr_ptr = reg_wr && (reg_addr == REG_SLOT_PTR);
	wire wr_ab = reg_wr && (reg_addr == REG_SEG_AB);
	wire wr_c = reg_wr && (reg_addr == REG_SEG_C);
	wire wr_d = reg_wr && (reg_addr == REG_SEG_D);
	wire wr_ef = reg_wr && (reg_addr == REG_SEG_EF);
	wire wr_map = reg_wr && (reg_addr == REG_MAP_CTRL);
	wire wr_size = reg_wr && (reg_addr == REG_DRAM_SIZE);
	// status index has no write decode, so it stays read-only

	// map control next value; software write beats the strap load
	wire [7:0] map_strap = {map_reg[7], strap_rel, map_reg[4:0]};
	wire [7:0] map_next = wr_map ? reg_wdata
		: strap_take ? map_strap : map_reg; // RL11

	// strap capture and ROM placement
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			// ROM placement defaults until the straps are taken
			strap_cnt_reg <= 2'h0;
			strap_done_reg <= 1'b0;
			rom_slot_reg <= 1'b0;
			rom_8bit_reg <= 1'b0;
		end else begin
			strap_cnt_reg <= strap_cnt_next;
			// one-time load, later strap changes are ignored
			if (strap_take) begin
				strap_done_reg <= 1'b1;
				rom_slot_reg <= strap_slot; // RL13
				rom_8bit_reg <= !strap_wide; // RL13
			end
		end
	end

	// software registers
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			// power-on values
			ptr_reg <= PTR_RST;
			seg_ab_reg <= SEG_RST;
			seg_c_reg <= SEG_RST;
			seg_d_reg <= SEG_RST;
			seg_ef_reg <= SEG_RST;
			map_reg <= MAP_RST;
			size_reg <= SIZE_RST;
		end else begin
			// slot boundary pointer
			if (wr_ptr) begin
				ptr_reg <= reg_wdata; // RL22
			end
			// A and B segment codes
			if (wr_ab) begin
				seg_ab_reg <= reg_wdata;
			end
			// C segment codes
			if (wr_c) begin
				seg_c_reg <= reg_wdata;
			end
			// D segment codes
			if (wr_d) begin
				seg_d_reg <= reg_wdata;
			end
			// E and F segment codes
			if (wr_ef) begin
				seg_ef_reg <= reg_wdata;
			end
			// map control also takes the strap load
			map_reg <= map_next;
			// installed DRAM in megabytes
			if (wr_size) begin
				size_reg <= reg_wdata;
			end
		end
	end

	// control fields
	wire [1:0] rel = {map_reg[MAP_REL_HI_BIT], map_reg[MAP_REL_LO_BIT]};
	wire remap_bit = map_reg[MAP_REMAP_BIT];

	// remap only for 1M to 4M of DRAM
	wire size_ok = (size_reg >= 8'h01) && (size_reg <= REMAP_MAX); // RL8
	wire remap_on = remap_bit && size_ok; // RL7

	// pointer normalisation
	wire ptr_mid = (ptr_reg >= PTR_MID_MIN) && (ptr_reg <= PTR_MID_MAX);
	wire [7:0] ptr_eff = ptr_mid ? PTR_MID_AS : ptr_reg; // RL4
	wire ptr_low = (ptr_eff >= PTR_LOW_MIN) && (ptr_eff <= PTR_LOW_MAX);
	wire ptr_zero = (ptr_reg == PTR_SRAM);

	// address classes, 64K granules
	wire [7:0] a_seg = req.addr[23:16];
	wire above_16m = req.addr[24];
	wire in_base = (a_seg < SEG_640K);
	wire in_win = (a_seg >= SEG_640K) && (a_seg < SEG_1M);
	wire top_rom = (req.addr[23:17] == ROM_TOP_128K);
	wire below_ptr = (a_seg < ptr_eff); // RL22

	// remapped window above the top of DRAM
	wire [7:0] top_seg = {size_reg[3:0], 4'h0};
	wire [7:0] top_end = 8'(top_seg + REMAP_LEN);
	wire in_remap = remap_on && (a_seg >= top_seg) && (a_seg < top_end);
	wire [7:0] remap_seg = 8'(a_seg - top_seg + SEG_640K); // RL7

	// shadow code of the window segment
	wire [1:0] raw_code = seg_code(req.addr[19:14], seg_ab_reg,
		seg_c_reg, seg_d_reg, seg_ef_reg);
	wire [1:0] code = remap_on ? 2'b00 : raw_code; // RL9

	// write uses low code bit, read high; 11 full DRAM
	wire win_dram = req.write ? code[0] : code[1]; // RL19 RL21
	wire win_rom_map = rom_space(req.addr[19:15], rel);
	// code 10 sends writes to the slot bus, never to ROM
	wire shadow_wr_slot = req.write && (code == 2'b10); // RL19
	wire win_rom = !win_dram && !shadow_wr_slot
		&& (win_rom_map || top_rom); // RL21

	// board choice per region
	wire base_board = ptr_low ? below_ptr : 1'b1; // RL2 RL5
	wire ext_board = !ptr_low && below_ptr; // RL5
	wire ext_rom = top_rom || (!ptr_low && !below_ptr
		&& (ptr_eff > PTR_SLOT_MAX)); // RL6

	// target resolution
	wire t_none = !req.valid || above_16m; // RL3
	wire t_board = !t_none && (in_remap
		|| (in_base && base_board)
		|| (in_win && win_dram)
		|| (!in_base && !in_win && ext_board && !top_rom));
	wire t_rom = !t_none && !in_remap && !t_board
		&& ((in_win && win_rom) || (!in_base && !in_win && ext_rom));
	// whatever is left lands on the slot bus
	wire t_slot = !t_none && !t_board && !t_rom; // RL2 RL6

	// DRAM address, relocation bits play no part
	wire [23:0] dram_addr = in_remap ? {remap_seg, req.addr[15:0]}
		: req.addr[23:0]; // RL12

	// next cycle record
	msd_cyc_t cyc_next;
	// bank selects stay off with pointer zero
	assign cyc_next.dram_start = t_board && !ptr_zero; // RL1
	assign cyc_next.sram_start = t_board && ptr_zero; // RL1
	assign cyc_next.rom_start = t_rom; // RL14
	assign cyc_next.slot_start = t_slot;
	assign cyc_next.no_cycle = req.valid && above_16m; // RL3
	// only ROM reads split; writes stay single wide
	assign cyc_next.split = t_rom && rom_8bit_reg && req.wide
		&& !req.write; // RL16
	assign cyc_next.dram_addr = t_board ? dram_addr : 24'h000000;

	// read data selection
	wire [7:0] strap_stat = {5'h00, remap_on, rom_8bit_reg, rom_slot_reg};
	wire [7:0] rdata_next =
		!reg_rd ? 8'h00
		: (reg_addr == REG_SLOT_PTR) ? ptr_reg
		: (reg_addr == REG_SEG_AB) ? seg_ab_reg
		: (reg_addr == REG_SEG_C) ? seg_c_reg
		: (reg_addr == REG_SEG_D) ? seg_d_reg
		: (reg_addr == REG_SEG_EF) ? seg_ef_reg
		: (reg_addr == REG_MAP_CTRL) ? map_reg
		: (reg_addr == REG_DRAM_SIZE) ? size_reg
		: (reg_addr == REG_STRAP_STAT) ? strap_stat
		: 8'h00;

	// cycle outputs, one clock after the request
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			// idle record, chip select high
			cyc_reg <= '0;
			rom_cs_n_reg <= 1'b1;
			rdata_reg <= 8'h00;
		end else begin
			// a fresh record every clock
			cyc_reg <= cyc_next;
			rom_cs_n_reg <= !t_rom; // RL14
			rdata_reg <= rdata_next;
		end
	end

	// upper local byte only for 8-bit ROM on local bus
	// no byte steering here; software duplicates data
	logic lane_hi_reg;
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			lane_hi_reg <= 1'b0;
		end else begin
			// follows the captured straps one clock later
			lane_hi_reg <= rom_8bit_reg && !rom_slot_reg; // RL14 RL15
		end
	end

	// port drive
	assign cyc = cyc_reg;
	assign rom_chip_select_n = rom_cs_n_reg;
	assign rom_on_slot_bus = rom_slot_reg;
	assign rom_8bit = rom_8bit_reg;
	assign rom_lane_hi = lane_hi_reg;
	assign reg_rdata = rdata_reg;
endmodule

// ===== dv/msd_decoder_properties.sv
`timescale 1ns/1ps
module msd_decoder_properties
	import msd_pkg::*;
#(
	parameter int REMAP_MB_MAX = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire msd_req_t req,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire msd_cyc_t cyc,
	input wire logic rom_chip_select_n,
	input wire logic rom_on_slot_bus,
	input wire logic rom_8bit,
	input wire logic rom_lane_hi,
	input wire logic [7:0] reg_rdata
);
	logic [1:0] rs_reg; // mirrors the design's two-stage reset release
	logic [7:0] ptr_reg; // pointer as last written
	wire [7:0] seg = req.addr[23:16];
	wire go = req.valid && !req.addr[24];
	default clocking @(posedge clk); endclocking
	default disable iff (!rs_reg[1]);
	// track reset release and pointer writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs_reg <= 2'h0;
			ptr_reg <= PTR_RST;
		end else begin
			rs_reg <= {rs_reg[0], 1'h1};
			if (reg_wr && reg_addr == REG_SLOT_PTR) ptr_reg <= reg_wdata;
		end
	end
	chk_cs_rom: assert property (rom_chip_select_n == !cyc.rom_start)
		else $error("chip select not tied to rom start");
	chk_lane_hi: assert property (rom_lane_hi == $past(rom_8bit && !rom_on_slot_bus))
		else $error("rom lane wrong");
	chk_far_none: assert property (req.valid && req.addr[24] |=> cyc.no_cycle
		&& !cyc.dram_start && !cyc.slot_start && !cyc.rom_start)
		else $error("access above 16M started a cycle");
	chk_sram_ptr: assert property (go && ptr_reg == PTR_SRAM |=> !cyc.dram_start)
		else $error("dram cycle with pointer zero");
	chk_low_board: assert property (go && ptr_reg inside {[PTR_LOW_MIN:PTR_LOW_MAX]}
		&& seg < ptr_reg |=> cyc.dram_start)
		else $error("below low pointer not on board");
	chk_low_slot: assert property (go && ptr_reg inside {[PTR_LOW_MIN:PTR_LOW_MAX]}
		&& seg >= ptr_reg && seg < SEG_640K |=> cyc.slot_start)
		else $error("above low pointer not on slots");
	chk_mid_ptr: assert property (go && ptr_reg inside {[PTR_MID_MIN:PTR_MID_MAX]}
		&& int'(seg) > REMAP_MB_MAX * 16 + 5 && req.addr[23:17] != ROM_TOP_128K
		|=> cyc.slot_start)
		else $error("mid pointer not decoded as 10h");
	chk_rom_top: assert property (go && req.addr[23:17] == ROM_TOP_128K |=> cyc.rom_start)
		else $error("top 128K not rom");
	chk_no_split: assert property (req.valid && req.write |=> !cyc.split)
		else $error("rom write split");
	chk_ptr_read: assert property (reg_rd && reg_addr == REG_SLOT_PTR |=> reg_rdata == ptr_reg)
		else $error("pointer read back wrong");
	cover property (cyc.split);
	cover property (cyc.sram_start);
	cover property (cyc.no_cycle);
endmodule
bind msd_decoder msd_decoder_properties #(.REMAP_MB_MAX(REMAP_MB_MAX)) msd_props_i (.*);

// ===== dv/msd_host.sv
`timescale 1ns/1ps
module msd_host
	import msd_pkg::*;
(
	input wire logic clk,
	output msd_req_t req,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// quiet bus at time zero
	initial {req, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	// memory request, held until the next request or release
	task mw(input logic [24:0] a, input logic [1:0] wm);
		@(posedge clk);
		req <= {1'h1, wm[0], wm[1], a};
	endtask
	// release: stale fields inverted so nothing leans on them
	task mi();
		@(posedge clk);
		req <= {1'h0, ~req[26:0]};
	endtask
	// register access; pointer codes 01h-03h are never issued
	task ra(input logic wr, input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= ad;
		reg_wdata <= (ad == REG_SLOT_PTR && d inside {[1:3]}) ? 8'h04 : d;
		@(posedge clk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		reg_addr <= ~ad;
		reg_wdata <= ~d;
	endtask
endmodule

// ===== dv/test_memory_space_decoder.sv
`timescale 1ns/1ps
module test_memory_space_decoder
	import msd_pkg::*;
();
	localparam logic [5:0] KD = 6'h20;
	localparam logic [5:0] KS = 6'h10;
	localparam logic [5:0] KR = 6'h08;
	localparam logic [5:0] KL = 6'h04;
	localparam logic [5:0] KN = 6'h02;
	localparam logic [15:0] ROM_TAB = 16'h390C; // rom hits per relocation code
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [1:0] strap_reloc = 2'h2;
	logic strap_rom_slot = 1'h0; // rom on local bus
	logic rom_width_strap = 1'h0; // 8-bit rom
	msd_req_t req;
	msd_cyc_t cyc;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, rom_chip_select_n, rom_on_slot_bus, rom_8bit, rom_lane_hi;
	logic [29:0] note;
	logic [29:0] eq[$]; // expected kind and dram address
	logic [7:0] rq[$]; // expected read data
	logic [31:0] lfsr = 32'h165B;
	logic rd_seen = 1'h0;
	int n_fail = 0;
	int n_tests = 0;
	int i, j;
	wire [5:0] kind = {cyc.dram_start, cyc.sram_start, cyc.rom_start, cyc.slot_start,
		cyc.no_cycle, cyc.split};
	msd_decoder msd_decoder_i (.*);
	msd_host msd_host_i (.*);
	always #5 clk = ~clk;
	task ck(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// wait for all notes to be consumed, bounded
	task drain();
		for (i = 0; i < 20 && (eq.size() > 0 || rq.size() > 0); i++) @(posedge clk);
		if (eq.size() > 0 || rq.size() > 0) n_fail++;
	endtask
	task t(input logic [24:0] a, input logic [1:0] wm, input logic [5:0] k,
		input logic [23:0] da = 24'h0);
		eq.push_back({k, da != 24'h0 ? da : a[23:0]});
		msd_host_i.mw(a, wm);
	endtask
	task w(input logic [7:0] ad, input logic [7:0] d);
		msd_host_i.ra(1'h1, ad, d);
	endtask
	task r(input logic [7:0] ad, input logic [7:0] d);
		rq.push_back(d);
		msd_host_i.ra(1'h0, ad, 8'h00);
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// watcher: oldest note against each result
	always @(posedge clk) begin
		rd_seen <= reg_rd;
		if (rd_seen) ck("reg_rdata", reg_rdata, rq.pop_front());
		if (|kind[5:1]) begin
			note = eq.size() > 0 ? eq.pop_front() : '1;
			ck("cycle kind", kind, note[29:24]);
			if (note[29]) ck("dram_addr", cyc.dram_addr, note[23:0]);
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		repeat (10) @(posedge clk);
		ck("rom_on_slot_bus", rom_on_slot_bus, 32'h0);
		ck("rom_8bit", rom_8bit, 32'h1);
		r(REG_MAP_CTRL, 8'h40);
		r(REG_STRAP_STAT, 8'h02);
		r(REG_SLOT_PTR, PTR_RST);
		r(REG_SEG_C, SEG_RST);
		r(8'h55, 8'h00);
		w(REG_STRAP_STAT, 8'hFF);
		r(REG_STRAP_STAT, 8'h02);
		t(25'h0F0000, 2'h2, KR | 6'h01);
		t(25'h0F0000, 2'h3, KR);
		t(25'h1000000, 2'h0, KN);
		t(25'hFE0000, 2'h0, KR);
		for (i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			t({6'h00, lfsr[18:0]}, {1'h0, lfsr[20]}, KD);
		end
		msd_host_i.mi();
		$display("base test done");
		for (i = 0; i < 4; i++) begin
			w(REG_MAP_CTRL, 8'(i << 5));
			for (j = 0; j < 4; j++)
				t({5'h00, 2'h3, j[1], 1'h0, j[0], 15'h0}, 2'h0, ROM_TAB[i*4+j] ? KR : KL);
			t(25'h001000, 2'h1, KD);
			msd_host_i.mi();
		end
		$display("relocation test done");
		w(REG_SEG_C, 8'h55);
		w(REG_SEG_C, 8'hE4);
		for (j = 0; j < 4; j++) begin
			// relocation 11 from the loop above puts C0000-CFFFF in ROM
			t({5'h00, 4'hC, j[1:0], 14'h0}, 2'h0, j[1] ? KD : KR);
			t({5'h00, 4'hC, j[1:0], 14'h0}, 2'h1, j[0] ? KD : j[1] ? KL : KR);
		end
		msd_host_i.mi();
		$display("shadow test done");
		w(REG_DRAM_SIZE, 8'h02);
		w(REG_MAP_CTRL, 8'h30);
		r(REG_STRAP_STAT, 8'h06);
		t(25'h200000, 2'h0, KD, 24'h0A0000);
		t(25'h25FFFF, 2'h1, KD, 24'h0FFFFF);
		t(25'h0CC000, 2'h0, KL);
		msd_host_i.mi();
		w(REG_DRAM_SIZE, 8'h05);
		r(REG_STRAP_STAT, 8'h02);
		t(25'h0CC000, 2'h0, KD);
		msd_host_i.mi();
		$display("remap test done");
		w(REG_SLOT_PTR, 8'h00);
		t(25'h001000, 2'h0, KS);
		t(25'h100000, 2'h0, KL);
		msd_host_i.mi();
		w(REG_SLOT_PTR, 8'h06);
		t(25'h050000, 2'h0, KD);
		t(25'h060000, 2'h1, KL);
		t(25'h300000, 2'h0, KL);
		t(25'h1000000, 2'h0, KN);
		msd_host_i.mi();
		w(REG_SLOT_PTR, 8'h0C);
		t(25'h500000, 2'h0, KL);
		t(25'h0FFFFF, 2'h0, KR);
		msd_host_i.mi();
		w(REG_SLOT_PTR, 8'h40);
		t(25'h3F0000, 2'h0, KD);
		t(25'h400000, 2'h0, KL);
		msd_host_i.mi();
		w(REG_SLOT_PTR, 8'h02);
		r(REG_SLOT_PTR, 8'h04);
		$display("pointer test done");
		drain();
		// second reset with the other strap settings
		strap_reloc <= 2'h1;
		strap_rom_slot <= 1'h1;
		rom_width_strap <= 1'h1;
		nrst <= 1'h0;
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		repeat (10) @(posedge clk);
		ck("rom_on_slot_bus", rom_on_slot_bus, 32'h1);
		ck("rom_8bit", rom_8bit, 32'h0);
		r(REG_MAP_CTRL, 8'h20);
		r(REG_STRAP_STAT, 8'h01);
		r(REG_SLOT_PTR, PTR_RST);
		t(25'h0F0000, 2'h2, KR);
		msd_host_i.mi();
		$display("strap test done");
		drain();
		complete_run();
	end
endmodule
